// [rtl/swd_chan_if.sv]
// Interface between the register block and one wake detection channel.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface swd_chan_if;
    import swd_pkg::*;
    swd_mode_type mode;
    logic enable;
    logic clear_edge;
    logic hit;
    logic [1:0] seen_edge;

    modport ctrl (output mode, output enable, output clear_edge, input hit, input seen_edge);
    modport chan (input mode, input enable, input clear_edge, output hit, output seen_edge);
endinterface
`default_nettype wire

// [rtl/swd_pkg.sv]
// Constants, field layout and mode codes of the standby wake detect block.
// Assumes a 32-bit APB register port and two asynchronous wake request pins.
// Behaviour
// - Channel one detection mode lives in bits 14-12; codes low, high, fall, rise, both.
// - Channel zero detection mode lives in bits 6-4, same encoding as channel one.
// - Channel one seen-edge report, read only, bits 11-10: 01 rise, 10 fall, 11 both.
// - Channel zero seen-edge report, read only, bits 3-2, same encoding.
// - Seen-edge report is meaningful only in either-edge mode 100.
// - Clearing a channel's wake interrupt through the clear register also clears its report.
package swd_pkg;

    typedef enum logic [2:0] {
        SWD_MODE_LOW = 3'h0,
        SWD_MODE_HIGH = 3'h1,
        SWD_MODE_FALL = 3'h2,
        SWD_MODE_RISE = 3'h3,
        SWD_MODE_BOTH = 3'h4
    } swd_mode_type;

    localparam int SWD_CHANNELS = 2;
    localparam int SWD_ADDR_W = 8;

    // Register byte offsets.
    localparam logic [7:0] SWD_OFS_MODE = 8'h00;
    localparam logic [7:0] SWD_OFS_CLEAR = 8'h04;
    localparam logic [7:0] SWD_OFS_STATUS = 8'h08;
    localparam logic [7:0] SWD_OFS_MASK = 8'h0C;

    // Field positions in the mode register; channel one sits 8 bits above channel zero.
    localparam int SWD_CH_STRIDE = 8;
    localparam int SWD_POS_ENABLE = 0;
    localparam int SWD_POS_EDGE = 2;
    localparam int SWD_POS_MODE = 4;

    // Values after reset.
    localparam logic [2:0] SWD_RST_MODE = 3'h2;
    localparam logic SWD_RST_ENABLE = 1'h0;
    localparam logic [1:0] SWD_RST_EDGE = 2'h0;
    localparam logic [1:0] SWD_RST_PEND = 2'h0;
    localparam logic [1:0] SWD_RST_MASK = 2'h0;

    // Seen-edge report codes.
    localparam logic [1:0] SWD_EDGE_RISE = 2'h1;
    localparam logic [1:0] SWD_EDGE_FALL = 2'h2;

endpackage

// [rtl/swd_top.sv]
// Standby wake detect configuration: APB slave, mode register, clear, status and mask.
// Assumes an APB master on pclk and two asynchronous wake pins.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module swd_top
    import swd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SWD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_input_zero,
    input wire logic wake_input_one,
    output logic wake_release,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic setup;
    logic access;
    logic hit_mode;
    logic hit_clear;
    logic hit_status;
    logic hit_mask;
    logic mapped;
    logic wr;
    logic [31:0] wmask;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_mode = paddr == SWD_OFS_MODE;
    assign hit_clear = paddr == SWD_OFS_CLEAR;
    assign hit_status = paddr == SWD_OFS_STATUS;
    assign hit_mask = paddr == SWD_OFS_MASK;
    assign mapped = hit_mode | hit_clear | hit_status | hit_mask;
    assign wr = access & pwrite & mapped;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Zero wait states; an unmapped address is answered with an error.
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    ////////////////////////////////////////////////////////////////////////////////
    // Channels.

    swd_chan_if ch_bus[SWD_CHANNELS] ();

    logic [SWD_CHANNELS-1:0] pins;
    logic [SWD_CHANNELS-1:0] hit;
    logic [SWD_CHANNELS-1:0] enable;
    logic [SWD_CHANNELS-1:0] next_enable;
    logic [SWD_CHANNELS-1:0] clear_edge;
    logic [2:0] mode [SWD_CHANNELS];
    logic [2:0] next_mode [SWD_CHANNELS];
    logic [1:0] seen [SWD_CHANNELS];
    logic [SWD_CHANNELS-1:0] pend;
    logic [SWD_CHANNELS-1:0] next_pend;
    logic [SWD_CHANNELS-1:0] mask;
    logic [SWD_CHANNELS-1:0] next_mask;
    logic [31:0] wdata_m;

    assign pins = {wake_input_one, wake_input_zero};
    assign wdata_m = pwdata & wmask;

    genvar gi;
    generate
        for (gi = 0; gi < SWD_CHANNELS; gi++) begin : g_ch
            localparam int BASE = gi * SWD_CH_STRIDE;

            assign ch_bus[gi].mode = swd_mode_type'(mode[gi]);
            assign ch_bus[gi].enable = enable[gi];
            assign ch_bus[gi].clear_edge = clear_edge[gi];
            assign hit[gi] = ch_bus[gi].hit;
            assign seen[gi] = ch_bus[gi].seen_edge;

            swd_wake_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .pin(pins[gi]),
                .ch(ch_bus[gi])
            );

            // Clear register write of a one, or status write-one-clear, ends the request.
            assign clear_edge[gi] = wr & (hit_clear | hit_status) & wdata_m[gi];

            always_comb begin
                next_mode[gi] = mode[gi];
                next_enable[gi] = enable[gi];
                if (wr && hit_mode && pstrb[(BASE / 8)]) begin
                    next_mode[gi] = pwdata[BASE + SWD_POS_MODE +: 3];
                    next_enable[gi] = pwdata[BASE + SWD_POS_ENABLE];
                end
                // An enabled channel's detection sets the pending bit; set beats clear.
                next_pend[gi] = (pend[gi] & ~clear_edge[gi]) | (enable[gi] & hit[gi]);
                next_mask[gi] = (wr && hit_mask && pstrb[0]) ? wdata_m[gi] : mask[gi];
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mode[gi] <= SWD_RST_MODE;
                    enable[gi] <= SWD_RST_ENABLE;
                end else begin
                    mode[gi] <= next_mode[gi];
                    enable[gi] <= next_enable[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= SWD_RST_PEND;
            mask <= SWD_RST_MASK;
        end else begin
            pend <= next_pend;
            mask <= next_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs towards standby control and the interrupt controller.

    logic next_release;
    logic next_irq;
    logic release_q;
    logic irq_q;

    // The interrupt follows the registered pending and mask bits, in step with the release.
    always_comb begin
        next_release = |pend;
        next_irq = |(pend & mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            release_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            release_q <= next_release;
            irq_q <= next_irq;
        end
    end

    assign wake_release = release_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle so that it comes from a flip-flop.

    logic [31:0] rd_mode;
    logic [31:0] rd_value;
    logic [31:0] next_prdata;
    logic [31:0] prdata_q;

    // Unused bits 15, 9, 7 and 1 read as zero and hold no storage.
    always_comb begin
        rd_mode = 32'h0;
        rd_mode[SWD_POS_MODE +: 3] = mode[0];
        rd_mode[SWD_POS_EDGE +: 2] = seen[0];
        rd_mode[SWD_POS_ENABLE] = enable[0];
        rd_mode[SWD_CH_STRIDE + SWD_POS_MODE +: 3] = mode[1];
        rd_mode[SWD_CH_STRIDE + SWD_POS_EDGE +: 2] = seen[1];
        rd_mode[SWD_CH_STRIDE + SWD_POS_ENABLE] = enable[1];
    end

    always_comb begin
        rd_value = 32'h0;
        if (hit_mode) begin
            rd_value = rd_mode;
        end else if (hit_status) begin
            rd_value[SWD_CHANNELS-1:0] = pend;
        end else if (hit_mask) begin
            rd_value[SWD_CHANNELS-1:0] = mask;
        end
        next_prdata = (setup && !pwrite) ? rd_value : prdata_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else begin
            prdata_q <= next_prdata;
        end
    end

    assign prdata = prdata_q;

endmodule // swd_top
`default_nettype wire

// [rtl/swd_wake_chan.sv]
// One wake request channel: pin synchroniser, level or edge detection, seen-edge report.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module swd_wake_chan
    import swd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    swd_chan_if.chan ch
);

    logic sync1;
    logic sync2;
    logic prev;
    logic [1:0] seen;
    logic [1:0] next_seen;
    logic rise;
    logic fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            seen <= SWD_RST_EDGE;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            prev <= sync2;
            seen <= next_seen;
        end
    end

    assign rise = sync2 & ~prev;
    assign fall = ~sync2 & prev;

    always_comb begin
        case (ch.mode)
            SWD_MODE_LOW: ch.hit = ~sync2;
            SWD_MODE_HIGH: ch.hit = sync2;
            SWD_MODE_FALL: ch.hit = fall;
            SWD_MODE_RISE: ch.hit = rise;
            SWD_MODE_BOTH: ch.hit = rise | fall;
            default: ch.hit = 1'b0;
        endcase
    end

    // A new edge wins over a clear in the same cycle.
    always_comb begin
        next_seen = ch.clear_edge ? SWD_RST_EDGE : seen;
        if (ch.enable && ch.mode == SWD_MODE_BOTH) begin
            if (rise) begin
                next_seen = next_seen | SWD_EDGE_RISE;
            end
            if (fall) begin
                next_seen = next_seen | SWD_EDGE_FALL;
            end
        end
    end

    assign ch.seen_edge = seen;

endmodule // swd_wake_chan
`default_nettype wire

// [tb/swd_checker.sv]
// Checker of the wake detect block, watching only the top module's ports.
// Assumes it is bound to every swd_top instance.
`timescale 1ns/1ps
`default_nettype none
module swd_checker
    import swd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SWD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wake_input_zero,
    input wire logic wake_input_one,
    input wire logic wake_release,
    input wire logic irq
);
    logic [2:0] m0, m1;
    logic en0, en1, en_any, rd_mode, acc;
    logic [1:0] msk;
    assign acc = psel && penable;
    assign rd_mode = acc && !pwrite && paddr == SWD_OFS_MODE;
    assign en_any = en0 | en1;
    // Shadow of the writable fields, kept from the APB writes seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m0 <= SWD_RST_MODE;
            m1 <= SWD_RST_MODE;
            en0 <= 1'b0;
            en1 <= 1'b0;
            msk <= 2'h0;
        end else if (acc && pwrite) begin
            if (paddr == SWD_OFS_MODE && pstrb[0]) {m0, en0} <= {pwdata[6:4], pwdata[0]};
            if (paddr == SWD_OFS_MODE && pstrb[1]) {m1, en1} <= {pwdata[14:12], pwdata[8]};
            if (paddr == SWD_OFS_MASK && pstrb[0]) msk <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_mode_readback: assert property (rd_mode |-> prdata[14:12] == m1 && prdata[6:4] == m0)
        else $error("mode field readback wrong");
    chk_enable_readback: assert property (rd_mode |-> prdata[8] == en1 && prdata[0] == en0)
        else $error("enable bit readback wrong");
    chk_reserved_zero: assert property (rd_mode |-> prdata[31:15] == 17'h0 && !prdata[7])
        else $error("reserved mode bits not zero");
    chk_clear_reads: assert property (acc && !pwrite && paddr == SWD_OFS_CLEAR |-> prdata == 32'h0)
        else $error("clear register read not zero");
    chk_unmapped_err: assert property (acc && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> pslverr)
        else $error("unmapped access without error");
    chk_quiet_off: assert property (!en_any && !$past(en_any) && !wake_release |=> !wake_release)
        else $error("wake release with both channels disabled");
    chk_irq_masked: assert property (msk == 2'h0 && $past(msk) == 2'h0 |-> !irq)
        else $error("interrupt raised while masked");
    chk_irq_wake: assert property (irq |-> wake_release)
        else $error("interrupt without pending wake");
    cov_both: cover property (rd_mode && prdata[3:2] == 2'h3);
    cov_irq: cover property ($rose(irq));
    cov_err: cover property (acc && pslverr);
endmodule // swd_checker
bind swd_top swd_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_input_zero(wake_input_zero),
    .wake_input_one(wake_input_one), .wake_release(wake_release), .irq(irq));
`default_nettype wire

// [tb/swd_top_tb_top.sv]
// Self-checking bench of the wake detect block, driven over its APB port.
// Assumes the wake pins settle within six clocks of a change.
`timescale 1ns/1ps
`default_nettype none
module swd_top_tb_top;
    import swd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pin0, pin1, pready, pslverr, wake_release, irq;
    logic err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    int error_cnt, checks_done;
    swd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wake_input_zero(pin0), .wake_input_one(pin1),
        .wake_release(wake_release), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        {pwrite, paddr, pwdata, pstrb} <= {w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(n, rd, e);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: a hang counts as a mismatch and ends the run.
    initial begin
        repeat (4000) @(posedge pclk);
        error_cnt++;
        test_done;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, pin0, pin1, presetn} = '0;
        error_cnt = 0;
        checks_done = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(SWD_OFS_MODE, 32'h0000_2020, "mode_reset");
        rdchk(SWD_OFS_STATUS, 32'h0, "status_reset");
        $display("test reset done");
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, SWD_OFS_MODE, {17'h0, m[2:0], 5'h0, m[2:0], 4'h0}, 4'h3);
            rdchk(SWD_OFS_MODE, {17'h0, m[2:0], 5'h0, m[2:0], 4'h0}, "mode_code");
        end
        $display("test modes done");
        apb(1'b1, SWD_OFS_MODE, 32'hFFFF_CECE, 4'hF);
        pin1 <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("wake_disabled", {31'h0, wake_release}, 32'h0);
        rdchk(SWD_OFS_MODE, 32'h0000_4040, "reserved_bits");
        // Enable comes in its own write after the mode.
        apb(1'b1, SWD_OFS_MODE, 32'h0000_4041, 4'hF);
        pin0 <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(SWD_OFS_MODE, 32'h0000_4045, "edge0_rise");
        chk("wake_on", {31'h0, wake_release}, 32'h1);
        pin0 <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk(SWD_OFS_MODE, 32'h0000_404D, "edge0_both");
        apb(1'b1, SWD_OFS_MASK, 32'h1, 4'h1);
        repeat (2) @(posedge pclk);
        chk("irq_on", {31'h0, irq}, 32'h1);
        apb(1'b1, SWD_OFS_CLEAR, 32'h1, 4'h1);
        repeat (2) @(posedge pclk);
        chk("irq_off", {30'h0, irq, wake_release}, 32'h0);
        rdchk(SWD_OFS_MODE, 32'h0000_4041, "edge0_clear");
        $display("test channel zero done");
        apb(1'b1, SWD_OFS_MODE, 32'h0000_4141, 4'hF);
        pin1 <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk(SWD_OFS_MODE, 32'h0000_4941, "edge1_fall");
        apb(1'b1, SWD_OFS_STATUS, 32'h3, 4'h1);
        rdchk(SWD_OFS_MODE, 32'h0000_4141, "edge1_clear");
        apb(1'b1, SWD_OFS_MODE, 32'h0000_4140, 4'h1);
        apb(1'b1, SWD_OFS_MODE, 32'h0000_4130, 4'h1);
        apb(1'b1, SWD_OFS_MODE, 32'h0000_4131, 4'h1);
        pin0 <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(SWD_OFS_MODE, 32'h0000_4131, "rise_no_report");
        rdchk(SWD_OFS_STATUS, 32'h1, "rise_pending");
        rdchk(SWD_OFS_CLEAR, 32'h0, "clear_read");
        apb(1'b0, 8'h10, 32'h0, 4'hF);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        $display("test channel one done");
        // Level modes: both channels are disabled before their modes change.
        apb(1'b1, SWD_OFS_MODE, 32'h0000_4030, 4'hF);
        apb(1'b1, SWD_OFS_MODE, 32'h0000_1000, 4'hF);
        apb(1'b1, SWD_OFS_CLEAR, 32'h3, 4'h1);
        apb(1'b1, SWD_OFS_MODE, 32'h0000_1100, 4'hF);
        pin1 <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(SWD_OFS_STATUS, 32'h2, "high_level");
        apb(1'b1, SWD_OFS_CLEAR, 32'h2, 4'h1);
        rdchk(SWD_OFS_STATUS, 32'h2, "level_holds");
        apb(1'b1, SWD_OFS_MODE, 32'h0000_1101, 4'hF);
        pin0 <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk(SWD_OFS_STATUS, 32'h3, "low_level");
        $display("test levels done");
        apb(1'b1, SWD_OFS_MODE, 32'h0000_1100, 4'hF);
        apb(1'b1, SWD_OFS_MODE, 32'h0000_1120, 4'hF);
        apb(1'b1, SWD_OFS_CLEAR, 32'h1, 4'h1);
        apb(1'b1, SWD_OFS_MODE, 32'h0000_1121, 4'hF);
        pin0 <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(SWD_OFS_STATUS, 32'h2, "fall_ignores_rise");
        pin0 <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk(SWD_OFS_STATUS, 32'h3, "fall_edge");
        rdchk(SWD_OFS_MODE, 32'h0000_1121, "fall_no_report");
        apb(1'b1, SWD_OFS_MASK, 32'h0, 4'h2);
        rdchk(SWD_OFS_MASK, 32'h1, "mask_strobe");
        $display("test falling edge done");
        test_done;
    end
endmodule // swd_top_tb_top
`default_nettype wire
